// ### sls_boot_ctrl.sv
/*
  strap latch and boot select: power-up sequencing from chip activation, strap capture,
  boot mode and rom log print decode, and post-reset clock source selection, with an
  apb slave for status and clock configuration.
  assumes chip_en, strap pads and the fuse field are synchronous to pclk and the fuse
  field is settled before chip_en rises.
*/
// Added by the designer: the address map and register access over APB.
`timescale 1ns/10ps
module sls_boot_ctrl
  import sls_pkg::*;
#(
  parameter int HOLD_CYCLES = STRAP_HOLD_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        chip_en,
  input  wire logic        boot_strap_a,
  input  wire logic        boot_strap_b,
  input  wire logic        boot_strap_c,
  input  wire logic [1:0]  rom_log_fuse_field,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             strap_c_pull_en,
  output logic             strap_gpio_release,
  output logic             strap_a_q,
  output logic             strap_b_q,
  output logic             strap_c_q,
  output logic             strap_valid,
  output sls_boot_e        boot_mode,
  output logic             rom_log_print_en,
  output sls_cpu_src_e     cpu_clk_src,
  output logic [7:0]       cpu_clk_div,
  output sls_slow_src_e    rtc_slow_src,
  output logic [8:0]       rtc_slow_div,
  output logic             rtc_fast_src,
  output logic [7:0]       rtc_fast_div
);

  sls_seq_e    state;
  sls_seq_e    next_state;
  logic        hold_done;
  logic        capture;
  logic        off;
  logic        held_a;
  logic        held_b;
  logic        held_c;
  logic [31:0] status_word;
  logic [31:0] clk_word;
  logic [31:0] next_rdata;
  logic        next_err;
  logic        setup;
  logic        cfg_wr;

  // ---------------------------------------------------------------------------
  // power-up sequence
  // ---------------------------------------------------------------------------
  // chip_en low is shutdown: everything but the apb slave returns to its reset picture
  always_comb begin
    next_state = state;
    case (state)
      SEQ_OFF:  if (chip_en) next_state = SEQ_HOLD;
      SEQ_HOLD: if (!chip_en) next_state = SEQ_OFF;
                else if (hold_done) next_state = SEQ_RUN;
      SEQ_RUN:  if (!chip_en) next_state = SEQ_OFF;
      default:  next_state = SEQ_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SEQ_OFF;
    end else if (ce) begin
      state <= next_state;
    end
  end

  sls_hold_timer #(
    .COUNT (HOLD_CYCLES)
  ) u_hold (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .run     (state == SEQ_HOLD && chip_en),
    .done    (hold_done)
  );

  // sample at the close of the window so the latest settled level wins
  assign capture = (state == SEQ_HOLD) && chip_en && hold_done;
  assign off     = !chip_en;

  // ---------------------------------------------------------------------------
  // strap latches
  // ---------------------------------------------------------------------------
  sls_strap_latch u_latch_a (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .clear   (off),
    .capture (capture),
    .pin     (boot_strap_a),
    .q       (strap_a_q),
    .held    (held_a)
  );

  sls_strap_latch u_latch_b (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .clear   (off),
    .capture (capture),
    .pin     (boot_strap_b),
    .q       (strap_b_q),
    .held    (held_b)
  );

  sls_strap_latch u_latch_c (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .clear   (off),
    .capture (capture),
    .pin     (boot_strap_c),
    .q       (strap_c_q),
    .held    (held_c)
  );

  // ---------------------------------------------------------------------------
  // pad control and decoded outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_c_pull_en    <= 1'b1;
      strap_gpio_release <= 1'b0;
      strap_valid        <= 1'b0;
    end else if (ce) begin
      strap_c_pull_en    <= (next_state != SEQ_RUN);
      strap_gpio_release <= (next_state == SEQ_RUN);
      strap_valid        <= held_a && held_b && held_c && chip_en;
    end
  end

  // decoded once the latches are full; fixed until shutdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_mode        <= BOOT_NONE;
      rom_log_print_en <= 1'b0;
    end else if (ce) begin
      if (state == SEQ_RUN) begin
        boot_mode        <= sls_boot_decode(strap_a_q, strap_b_q, strap_c_q);
        rom_log_print_en <= sls_print_decode(rom_log_fuse_field, strap_b_q);
      end else begin
        boot_mode        <= BOOT_NONE;
        rom_log_print_en <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // clock selection
  // ---------------------------------------------------------------------------
  assign setup  = psel && !penable;
  assign cfg_wr = psel && penable && pready && pwrite && !pslverr && (paddr == ADDR_CLK_CFG);

  // unsupported source codes are dropped so a stray write cannot stop a clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_src  <= CPU_SRC_RST;
      cpu_clk_div  <= CPU_DIV_RST;
      rtc_slow_src <= SLOW_SRC_RST;
      rtc_fast_src <= FAST_SRC_RST;
      rtc_fast_div <= FAST_DIV_RST;
    end else if (ce) begin
      if (off) begin
        cpu_clk_src  <= CPU_SRC_RST;
        cpu_clk_div  <= CPU_DIV_RST;
        rtc_slow_src <= SLOW_SRC_RST;
        rtc_fast_src <= FAST_SRC_RST;
        rtc_fast_div <= FAST_DIV_RST;
      end else if (cfg_wr) begin
        if (pwdata[CC_CPU_SRC_LSB +: 2] != 2'h3) begin
          cpu_clk_src <= sls_cpu_src_e'(pwdata[CC_CPU_SRC_LSB +: 2]);
        end
        cpu_clk_div <= pwdata[CC_CPU_DIV_LSB +: 8];
        if (pwdata[CC_SLOW_SRC_LSB +: 2] != 2'h3) begin
          rtc_slow_src <= sls_slow_src_e'(pwdata[CC_SLOW_SRC_LSB +: 2]);
        end
        rtc_fast_src <= pwdata[CC_FAST_SRC_BIT];
        rtc_fast_div <= pwdata[CC_FAST_DIV_LSB +: 8];
      end
    end
  end

  // the fast rc feeds the slow domain only through the fixed prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_slow_div <= SLOW_NO_PREDIV;
    end else if (ce) begin
      if (off) begin
        rtc_slow_div <= SLOW_NO_PREDIV;
      end else if (cfg_wr && pwdata[CC_SLOW_SRC_LSB +: 2] == SLOW_SRC_FAST_RC) begin
        rtc_slow_div <= SLOW_RC_PREDIV;
      end else if (cfg_wr && pwdata[CC_SLOW_SRC_LSB +: 2] != 2'h3) begin
        rtc_slow_div <= SLOW_NO_PREDIV;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------------------
  always_comb begin
    status_word = '0;
    status_word[ST_STRAP_A_BIT]     = strap_a_q;
    status_word[ST_STRAP_B_BIT]     = strap_b_q;
    status_word[ST_STRAP_C_BIT]     = strap_c_q;
    status_word[ST_VALID_BIT]       = strap_valid;
    status_word[ST_BOOT_LSB +: 2]   = boot_mode;
    status_word[ST_PRINT_BIT]       = rom_log_print_en;
    status_word[ST_SEQ_LSB +: 2]    = state;
    status_word[ST_FUSE_LSB +: 2]   = rom_log_fuse_field;
    clk_word = '0;
    clk_word[CC_CPU_SRC_LSB +: 2]   = cpu_clk_src;
    clk_word[CC_CPU_DIV_LSB +: 8]   = cpu_clk_div;
    clk_word[CC_SLOW_SRC_LSB +: 2]  = rtc_slow_src;
    clk_word[CC_FAST_SRC_BIT]       = rtc_fast_src;
    clk_word[CC_FAST_DIV_LSB +: 8]  = rtc_fast_div;
  end

  // status is read-only: a write there is refused, never stored
  always_comb begin
    next_rdata = '0;
    next_err   = 1'b0;
    if (paddr == ADDR_STATUS) begin
      next_rdata = pwrite ? 32'h0000_0000 : status_word;
      next_err   = pwrite;
    end else if (paddr == ADDR_CLK_CFG) begin
      next_rdata = pwrite ? 32'h0000_0000 : clk_word;
    end else begin
      next_err   = 1'b1;
    end
  end

  // one wait-free access phase: answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (ce) begin
      pready <= setup;
      if (setup) begin
        pslverr <= next_err;
        prdata  <= next_rdata;
      end else if (pready) begin
        pslverr <= 1'b0;
        prdata  <= '0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  hold_to_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state == SEQ_HOLD && chip_en && hold_done) |=> state == SEQ_RUN && strap_gpio_release)
    else $error("hold window end did not enter run");

  latch_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == SEQ_RUN && chip_en) |=> $stable(strap_a_q) && $stable(strap_b_q) && $stable(strap_c_q))
    else $error("strap latch changed while running");

  early_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state == SEQ_HOLD && !hold_done) |=> !strap_valid)
    else $error("straps valid before hold window closed");

  pullup_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    strap_c_pull_en == (state != SEQ_RUN) && strap_gpio_release == (state == SEQ_RUN))
    else $error("strap c pull or release wrong for sequence state");

  boot_flash_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state == SEQ_RUN && strap_a_q && strap_c_q) |=> boot_mode == BOOT_FLASH)
    else $error("flash boot not decoded");

  boot_download_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state == SEQ_RUN && strap_a_q && strap_b_q && !strap_c_q) |=> boot_mode == BOOT_DOWNLOAD)
    else $error("download boot not decoded");

  print_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state == SEQ_RUN && rom_log_fuse_field == 2'h2) |=> rom_log_print_en == $past(strap_b_q))
    else $error("print enable does not follow strap b for fuse 2");

  print_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rom_log_fuse_field == 2'h3 && $past(rom_log_fuse_field) == 2'h3) |-> !rom_log_print_en)
    else $error("print enabled with fuse 3");

  cpu_default_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !chip_en) |=> cpu_clk_src == CPU_SRC_XTAL && cpu_clk_div == CPU_DIV_RST)
    else $error("cpu clock not back at crystal divided by two");

  slow_prediv_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rtc_slow_src == SLOW_SRC_FAST_RC) |-> rtc_slow_div == SLOW_RC_PREDIV)
    else $error("fast rc slow source without 256 prescaler");

endmodule

// ### sls_pkg.sv
/*
  constants, types and decode helpers for the strap latch and boot select block.
  assumes one 100 MHz register clock; the chip activation level and strap pad levels
  arrive already synchronous to it.
*/
package sls_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 10;
  localparam int RAIL_SETTLE_US     = 50;
  localparam int RESET_LOW_US       = 50;
  localparam int STRAP_SETUP_MS     = 0;
  localparam int STRAP_HOLD_MS      = 3;
  localparam int RAIL_SETTLE_CYCLES = (RAIL_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_LOW_CYCLES   = (RESET_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRAP_HOLD_CYCLES  = (STRAP_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] ADDR_STATUS   = 12'h000;
  localparam logic [11:0] ADDR_CLK_CFG  = 12'h004;

  localparam int ST_STRAP_A_BIT = 0;
  localparam int ST_STRAP_B_BIT = 1;
  localparam int ST_STRAP_C_BIT = 2;
  localparam int ST_VALID_BIT   = 3;
  localparam int ST_BOOT_LSB    = 4;
  localparam int ST_PRINT_BIT   = 6;
  localparam int ST_SEQ_LSB     = 7;
  localparam int ST_FUSE_LSB    = 9;

  localparam int CC_CPU_SRC_LSB  = 0;
  localparam int CC_CPU_DIV_LSB  = 8;
  localparam int CC_SLOW_SRC_LSB = 16;
  localparam int CC_FAST_SRC_BIT = 20;
  localparam int CC_FAST_DIV_LSB = 24;

  localparam logic [7:0] CPU_DIV_RST   = 8'h02;
  localparam logic [7:0] FAST_DIV_RST  = 8'h01;
  localparam logic [8:0] SLOW_RC_PREDIV = 9'h100;
  localparam logic [8:0] SLOW_NO_PREDIV = 9'h001;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_OFF  = 2'b00,
    SEQ_HOLD = 2'b01,
    SEQ_RUN  = 2'b10
  } sls_seq_e;

  typedef enum logic [1:0] {
    BOOT_NONE     = 2'b00,
    BOOT_FLASH    = 2'b01,
    BOOT_DOWNLOAD = 2'b10,
    BOOT_INVALID  = 2'b11
  } sls_boot_e;

  typedef enum logic [1:0] {
    CPU_SRC_XTAL = 2'b00,
    CPU_SRC_RC   = 2'b01,
    CPU_SRC_PLL  = 2'b10
  } sls_cpu_src_e;

  typedef enum logic [1:0] {
    SLOW_SRC_XTAL32K = 2'b00,
    SLOW_SRC_SLOW_RC = 2'b01,
    SLOW_SRC_FAST_RC = 2'b10
  } sls_slow_src_e;

  localparam sls_cpu_src_e  CPU_SRC_RST  = CPU_SRC_XTAL;
  localparam sls_slow_src_e SLOW_SRC_RST = SLOW_SRC_SLOW_RC;
  localparam logic          FAST_SRC_RST = 1'b0;

  // ---------------------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------------------
  function automatic sls_boot_e sls_boot_decode(input logic a, input logic b, input logic c);
    sls_boot_e m;
    m = BOOT_NONE;
    if (!b && !c) begin
      m = BOOT_INVALID;
    end else if (a && c) begin
      m = BOOT_FLASH;
    end else if (a && b && !c) begin
      m = BOOT_DOWNLOAD;
    end
    return m;
  endfunction

  function automatic logic sls_print_decode(input logic [1:0] fuse, input logic b);
    logic en;
    case (fuse)
      2'h0:    en = 1'b1;
      2'h1:    en = ~b;
      2'h2:    en = b;
      default: en = 1'b0;
    endcase
    return en;
  endfunction

endpackage

// ### sls_strap_latch.sv
/*
  one strap latch: catches its pad level once per power cycle.
  assumes the caller pulses capture once, at the end of the hold window.
*/
`timescale 1ns/10ps
module sls_strap_latch
  import sls_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic clear,
  input  wire logic capture,
  input  wire logic pin,
  output logic      q,
  output logic      held
);

  // ---------------------------------------------------------------------------
  // latch
  // ---------------------------------------------------------------------------
  // once held, only shutdown (clear) or presetn reopens the latch; no write path exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q    <= 1'b0;
      held <= 1'b0;
    end else if (ce) begin
      if (clear) begin
        q    <= 1'b0;
        held <= 1'b0;
      end else if (capture && !held) begin
        q    <= pin;
        held <= 1'b1;
      end
    end
  end

endmodule

// ### sls_hold_timer.sv
/*
  hold window timer: counts while run is high, flags done on the last cycle.
  assumes run drops whenever the window is abandoned, which restarts the count.
*/
`timescale 1ns/10ps
module sls_hold_timer
  import sls_pkg::*;
#(
  parameter int COUNT = STRAP_HOLD_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic run,
  output logic      done
);

  localparam int                 CW   = $clog2(COUNT + 1);
  localparam logic [CW-1:0]      LAST = CW'(COUNT - 1);

  logic [CW-1:0] cnt;

  // ---------------------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (ce) begin
      if (!run || done) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + CW'(1);
      end
    end
  end

  assign done = run && (cnt == LAST);

endmodule

// ### sls_board_model.sv
/*
  board side of the strap latch block: supply timing, strap drivers and chip activation.
  assumes one caller at a time uses its tasks, from the bench's main process.
*/
`timescale 1ns/10ps
module sls_board_model
  import sls_pkg::*;
#(
  parameter int SETTLE = RAIL_SETTLE_CYCLES,
  parameter int LOW    = RESET_LOW_CYCLES
) (
  input  wire logic pclk,
  input  wire logic strap_c_pull_en,
  output logic      chip_en,
  output logic      boot_strap_a,
  output logic      boot_strap_b,
  output logic      boot_strap_c
);
  logic c_val;
  logic c_drv;

  initial begin
    chip_en = 1'b0;
    boot_strap_a = 1'b1;
    boot_strap_b = 1'b1;
    c_val = 1'b1;
    c_drv = 1'b1;
  end

  // undriven pad: pull-up wins, else the opposite of what was last driven
  assign boot_strap_c = c_drv ? c_val : (strap_c_pull_en ? 1'b1 : ~c_val);

  // ---------------------------------------------------------------------------
  // board actions
  // ---------------------------------------------------------------------------
  task power_up(input logic [3:0] p);
    @(posedge pclk);
    {boot_strap_a, boot_strap_b, c_val, c_drv} <= p;
    repeat (SETTLE) @(posedge pclk);
    chip_en <= 1'b1; // straps stay put until reuse_pins
  endtask

  // short drop on purpose: must restart the hold window
  task restart_hold;
    @(posedge pclk);
    chip_en <= 1'b0;
    @(posedge pclk);
    chip_en <= 1'b1;
  endtask

  task reuse_pins;
    @(posedge pclk);
    boot_strap_a <= ~boot_strap_a;
    boot_strap_b <= ~boot_strap_b;
    c_val <= ~boot_strap_c;
    c_drv <= 1'b1;
  endtask

  task shut_down;
    @(posedge pclk);
    chip_en <= 1'b0;
    repeat (LOW) @(posedge pclk);
  endtask
endmodule

// ### sls_boot_ctrl_bench.sv
/*
  self-checking bench for the strap latch and boot select block.
  assumes the board model drives activation and straps; the bench is the apb master.
*/
`timescale 1ns/10ps
module sls_boot_ctrl_bench import sls_pkg::*;;
  localparam int HOLD = 20;
  localparam int SETTLE = 50;
  typedef struct packed {
    logic [3:0] pins;
    logic [1:0] fuse;
    sls_boot_e  boot;
    logic       prn;
  } sls_row_s;
  logic pclk, presetn, ce, chip_en, boot_strap_a, boot_strap_b, boot_strap_c;
  logic psel, penable, pwrite, pready, pslverr, err, rtc_fast_src;
  logic strap_c_pull_en, strap_gpio_release, strap_a_q, strap_b_q, strap_c_q, strap_valid, rom_log_print_en;
  logic [1:0]  fuse;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic [7:0]  cpu_clk_div, rtc_fast_div;
  logic [8:0]  rtc_slow_div;
  sls_boot_e     boot_mode;
  sls_cpu_src_e  cpu_clk_src;
  sls_slow_src_e rtc_slow_src;
  int          error_cnt, num_checks;
  sls_row_s    rows [7];
  sls_row_s    r;

  sls_boot_ctrl #(.HOLD_CYCLES(HOLD)) i_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .chip_en(chip_en), .boot_strap_a(boot_strap_a),
    .boot_strap_b(boot_strap_b), .boot_strap_c(boot_strap_c), .rom_log_fuse_field(fuse),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .strap_c_pull_en(strap_c_pull_en),
    .strap_gpio_release(strap_gpio_release), .strap_a_q(strap_a_q), .strap_b_q(strap_b_q),
    .strap_c_q(strap_c_q), .strap_valid(strap_valid), .boot_mode(boot_mode),
    .rom_log_print_en(rom_log_print_en), .cpu_clk_src(cpu_clk_src), .cpu_clk_div(cpu_clk_div),
    .rtc_slow_src(rtc_slow_src), .rtc_slow_div(rtc_slow_div), .rtc_fast_src(rtc_fast_src),
    .rtc_fast_div(rtc_fast_div));

  sls_board_model #(.SETTLE(SETTLE), .LOW(SETTLE)) i_brd (
    .pclk(pclk), .strap_c_pull_en(strap_c_pull_en), .chip_en(chip_en),
    .boot_strap_a(boot_strap_a), .boot_strap_b(boot_strap_b), .boot_strap_c(boot_strap_c));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task summarize;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      summarize();
    end
  endtask

  task wait_valid;
    int n;
    n = 0;
    while (strap_valid !== 1'b1 && n < 4 * HOLD) begin
      @(posedge pclk);
      n++;
    end
    if (strap_valid !== 1'b1) begin
      error_cnt++;
      summarize();
    end
  endtask

  task chk_defaults;
    @(posedge pclk);
    chk({strap_gpio_release, strap_c_pull_en, strap_valid}, 3'b010);
    chk({cpu_clk_src, cpu_clk_div, rtc_slow_src, rtc_slow_div, rtc_fast_src, rtc_fast_div},
        {CPU_SRC_RST, CPU_DIV_RST, SLOW_SRC_RST, SLOW_NO_PREDIV, FAST_SRC_RST, FAST_DIV_RST});
    apb(1'b0, ADDR_CLK_CFG, '0);
    chk(rd, {FAST_DIV_RST, 3'h0, FAST_SRC_RST, 2'h0, SLOW_SRC_RST, CPU_DIV_RST, 6'h0, CPU_SRC_RST});
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    fuse = '0;
    error_cnt = 0;
    num_checks = 0;
    // pins are a, b, c, c driven; no row has b=0 with c=0
    rows = '{'{4'b1011, 2'h0, BOOT_FLASH, 1'b1}, '{4'b1111, 2'h1, BOOT_FLASH, 1'b0},
             '{4'b1101, 2'h2, BOOT_DOWNLOAD, 1'b1}, '{4'b0111, 2'h3, BOOT_NONE, 1'b0},
             '{4'b1011, 2'h1, BOOT_FLASH, 1'b1}, '{4'b1110, 2'h2, BOOT_FLASH, 1'b1},
             '{4'b0101, 2'h0, BOOT_NONE, 1'b1}};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk_defaults;
    foreach (rows[i]) begin
      r = rows[i];
      fuse <= r.fuse;
      i_brd.power_up(r.pins);
      wait_valid;
      chk({strap_a_q, strap_b_q, strap_c_q}, r.pins[3:1]);
      chk(boot_mode, r.boot);
      chk(rom_log_print_en, r.prn);
      chk({strap_gpio_release, strap_c_pull_en}, 2'b10);
      apb(1'b0, ADDR_STATUS, '0);
      chk(rd, {21'h0, r.fuse, SEQ_RUN, r.prn, r.boot, 1'b1, r.pins[1], r.pins[2], r.pins[3]});
      apb(1'b1, ADDR_STATUS, '1);
      chk(err, 1'b1);
      i_brd.reuse_pins;
      repeat (3) @(posedge pclk);
      chk({strap_a_q, strap_b_q, strap_c_q, boot_mode, rom_log_print_en}, {r.pins[3:1], r.boot, r.prn});
      i_brd.shut_down;
      chk({strap_valid, strap_a_q, strap_gpio_release, strap_c_pull_en}, 4'b0001);
    end
    // activation drop inside the hold window starts the count again
    i_brd.power_up(4'b1011);
    repeat (HOLD - 5) @(posedge pclk);
    i_brd.restart_hold;
    repeat (HOLD - 5) @(posedge pclk);
    chk(strap_valid, 1'b0);
    wait_valid;
    for (int i = 0; i < 3; i++) begin
      w = {8'(i + 5), 3'h0, 1'(i), 2'h0, 2'(i), 8'(i + 3), 6'h0, 2'(i)};
      apb(1'b1, ADDR_CLK_CFG, w);
      // the write lands at the edge that ends the access phase
      @(posedge pclk);
      chk({cpu_clk_src, cpu_clk_div, rtc_slow_src, rtc_fast_src, rtc_fast_div},
          {2'(i), 8'(i + 3), 2'(i), 1'(i), 8'(i + 5)});
      chk(rtc_slow_div, (i == 2) ? SLOW_RC_PREDIV : SLOW_NO_PREDIV);
      apb(1'b0, ADDR_CLK_CFG, '0);
      chk(err, 1'b0);
      chk(rd, w);
    end
    // unused source code 3 leaves both sources as they were
    apb(1'b1, ADDR_CLK_CFG, {8'h09, 3'h0, 1'b1, 2'h0, 2'h3, 8'h07, 6'h0, 2'h3});
    @(posedge pclk);
    chk({cpu_clk_src, cpu_clk_div, rtc_slow_src, rtc_fast_src, rtc_fast_div},
        {CPU_SRC_PLL, 8'h07, SLOW_SRC_FAST_RC, 1'b1, 8'h09});
    apb(1'b0, 12'h008, '0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk_defaults;
    // clock enable low freezes the hold window, so capture waits for it
    ce <= 1'b0;
    repeat (2 * HOLD) @(posedge pclk);
    chk({strap_valid, strap_gpio_release}, 2'b00);
    ce <= 1'b1;
    wait_valid;
    chk({strap_a_q, strap_b_q, strap_c_q}, 3'b101);
    summarize();
  end
endmodule
